//--- hw/lmac_core.sv
// Purpose: lower mac service point, transmit and receive paths
// Assumes: rx symbols arrive one per cycle with no back-pressure
// Notes: symbols carry {parity, data}, swapped on odd positions
// Function
// - crc, interleave, scramble both ways; coding on transmit only, receive takes the systematic bit
// - slot flag picks training; detected training gives flag
// - request and indication carry their parameters
// - code never sent; wrong code fails, discarded
// - block length equals channel sdu size where one is set, else 1..268
// - code is country, network, colour, msb first
// - exclusive pdu-to-channel mappings enforced
// - shared pdu-to-channel mappings enforced
// - pass on the supplied rssi, report transfer exceptions
`timescale 1ns/1ps
`default_nettype none
module lmac_core
  import lmac_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // transmit request
  input wire logic txReqValid,
  output logic txReqReady,
  input wire logic [BLK_W-1:0] txBlock,
  input wire logic [LEN_W-1:0] txLength,
  input wire logic [3:0] txChan,
  input wire logic [3:0] txPdu,
  input wire logic [9:0] txCountry,
  input wire logic [13:0] txNetwork,
  input wire logic [5:0] txColour,
  input wire logic txSlotFlag,
  // transmit result
  output logic txDone,
  output logic txReject,
  output logic [RPT_W-1:0] txRejectCode,
  output logic [1:0] txTrainSeq,
  // coded symbols out
  output logic txSymValid,
  input wire logic txSymReady,
  output logic [SYM_W-1:0] txSymData,
  output logic txSymLast,
  // receive burst in
  input wire logic rxStart,
  input wire logic [LEN_W-1:0] rxLength,
  input wire logic [3:0] rxChan,
  input wire logic [CODE_W-1:0] rxCode,
  input wire logic [1:0] rxTrainSeq,
  input wire logic [7:0] rxRssi,
  input wire logic rxSymValid,
  input wire logic [SYM_W-1:0] rxSymData,
  // receive indication
  output logic rxIndValid,
  output logic [BLK_W-1:0] rxIndBlock,
  output logic [LEN_W-1:0] rxIndLength,
  output logic [3:0] rxIndChan,
  output logic rxIndCrcPass,
  output logic rxIndSlotFlag,
  output logic [7:0] rxIndRssi,
  output logic rxIndRptValid,
  output logic [RPT_W-1:0] rxIndRpt
);
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00, ST_DATA = 2'b01, ST_CRC = 2'b10
  } lmac_state_t;

  // sdu size for a channel, zero where any length up to the maximum is taken
  function automatic logic [LEN_W-1:0] chanSize(input logic [3:0] ch);
    logic [LEN_W-1:0] s;
    s = '0;
    case (ch)
      CH_SCH_HU: s = SIZE_SCH_HU;
      CH_SCH_F: s = SIZE_SCH_F;
      CH_STCH: s = SIZE_STCH;
      CH_SCH_HD: s = SIZE_SCH_HD;
      default: s = '0;
    endcase
    return s;
  endfunction

  // true when the length suits the channel
  function automatic logic lenOk(input logic [3:0] ch, input logic [LEN_W-1:0] len);
    logic [LEN_W-1:0] s;
    s = chanSize(ch);
    return (s == '0) ? (len != '0 && len <= SIZE_MAX) : (len == s);
  endfunction

  // pdu-to-channel mapping check
  function automatic logic mapOk(input logic [3:0] pdu, input logic [3:0] ch);
    logic ok;
    ok = 1'b0;
    case (pdu)
      PDU_ACC_ASSIGN: ok = (ch == CH_AACH);
      PDU_ACCESS, PDU_END_HU: ok = (ch == CH_SCH_HU);
      PDU_TRAFFIC: ok = (ch == CH_TCH);
      PDU_SYNC: ok = (ch == CH_BSCH);
      PDU_ACC_DEFINE, PDU_RESOURCE, PDU_END:
        ok = (ch == CH_SCH_HD) || (ch == CH_SCH_F) || (ch == CH_STCH);
      PDU_DATA: ok = (ch == CH_SCH_F) || (ch == CH_STCH);
      PDU_FRAG: ok = (ch == CH_SCH_HD) || (ch == CH_SCH_F);
      PDU_USIGNAL: ok = (ch == CH_STCH);
      PDU_SYSINFO: ok = (ch == CH_SCH_HD) || (ch == CH_STCH);
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction

  // transmit state
  lmac_state_t txState_reg, txState_next;
  logic [BLK_W-1:0] txShift_reg, txShift_next; // bits still to send
  logic [LEN_W-1:0] txCnt_reg, txCnt_next; // bits left in this phase
  logic [CRC_W-1:0] txCrc_reg, txCrc_next; // running crc
  logic [3:0] txConv_reg, txConv_next; // encoder memory
  logic txOdd_reg, txOdd_next; // interleave phase
  logic txReady_reg, txReady_next;
  logic txDone_reg, txDone_next;
  logic txRej_reg, txRej_next;
  logic [RPT_W-1:0] txRejCode_reg, txRejCode_next;
  logic [1:0] txTrain_reg, txTrain_next;
  logic txScrLoad, txScrStep, txScrBit;
  logic [CODE_W-1:0] txSeed;
  logic txBit, txSys, txPar;
  lmac_strm_if #(.W(SYM_W)) symIn ();
  lmac_strm_if #(.W(SYM_W)) symOut ();

  // extended colour code, country first, each field msb first
  assign txSeed = {txCountry, txNetwork, txColour};

  // transmit next state
  always_comb begin
    txState_next = txState_reg;
    txShift_next = txShift_reg;
    txCnt_next = txCnt_reg;
    txCrc_next = txCrc_reg;
    txConv_next = txConv_reg;
    txOdd_next = txOdd_reg;
    txReady_next = txReady_reg;
    txDone_next = 1'b0;
    txRej_next = 1'b0;
    txRejCode_next = txRejCode_reg;
    txTrain_next = txTrain_reg;
    txScrLoad = 1'b0;
    txScrStep = 1'b0;
    // data bits first, then the inverted crc
    txBit = (txState_reg == ST_DATA) ? txShift_reg[BLK_W-1] : ~txCrc_reg[CRC_W-1];
    txSys = txBit ^ txScrBit;
    txPar = txBit ^ txConv_reg[1] ^ txConv_reg[3] ^ txScrBit;
    symIn.valid = (txState_reg != ST_IDLE);
    symIn.data = txOdd_reg ? {txSys, txPar} : {txPar, txSys};
    symIn.last = (txState_reg == ST_CRC) && (txCnt_reg == 9'h001);
    unique case (txState_reg)
      ST_IDLE: begin
        if (txReady_reg && txReqValid) begin
          if (!lenOk(txChan, txLength)) begin
            txRej_next = 1'b1;
            txRejCode_next = RPT_LEN;
          end else if (!mapOk(txPdu, txChan)) begin
            txRej_next = 1'b1;
            txRejCode_next = RPT_MAP;
          end else begin
            txShift_next = txBlock;
            txCnt_next = txLength;
            txCrc_next = CRC_INIT;
            txConv_next = 4'h0;
            txOdd_next = 1'b0;
            txScrLoad = 1'b1;
            txTrain_next = txSlotFlag ? TRAIN_STOLEN : TRAIN_NORMAL;
            txReady_next = 1'b0;
            txState_next = ST_DATA;
          end
        end
      end
      ST_DATA: begin
        if (symIn.ready) begin
          txShift_next = {txShift_reg[BLK_W-2:0], 1'b0};
          txCrc_next = {txCrc_reg[CRC_W-2:0], 1'b0}
            ^ ((txBit ^ txCrc_reg[CRC_W-1]) ? CRC_POLY : 16'h0000);
          txConv_next = {txConv_reg[2:0], txBit};
          txOdd_next = ~txOdd_reg;
          txScrStep = 1'b1;
          txCnt_next = txCnt_reg - 9'h001;
          if (txCnt_reg == 9'h001) begin
            txCnt_next = CRC_BITS;
            txState_next = ST_CRC;
          end
        end
      end
      ST_CRC: begin
        if (symIn.ready) begin
          txCrc_next = {txCrc_reg[CRC_W-2:0], 1'b0};
          txConv_next = {txConv_reg[2:0], txBit};
          txOdd_next = ~txOdd_reg;
          txScrStep = 1'b1;
          txCnt_next = txCnt_reg - 9'h001;
          if (txCnt_reg == 9'h001) begin
            txDone_next = 1'b1;
            txReady_next = 1'b1;
            txState_next = ST_IDLE;
          end
        end
      end
    endcase
  end

  // transmit registers
  always_ff @(posedge clk) begin
    if (srst) begin
      txState_reg <= ST_IDLE;
      txShift_reg <= '0;
      txCnt_reg <= '0;
      txCrc_reg <= CRC_INIT;
      txConv_reg <= 4'h0;
      txOdd_reg <= 1'b0;
      txReady_reg <= 1'b1;
      txDone_reg <= 1'b0;
      txRej_reg <= 1'b0;
      txRejCode_reg <= RPT_NONE;
      txTrain_reg <= TRAIN_NORMAL;
    end else begin
      txState_reg <= txState_next;
      txShift_reg <= txShift_next;
      txCnt_reg <= txCnt_next;
      txCrc_reg <= txCrc_next;
      txConv_reg <= txConv_next;
      txOdd_reg <= txOdd_next;
      txReady_reg <= txReady_next;
      txDone_reg <= txDone_next;
      txRej_reg <= txRej_next;
      txRejCode_reg <= txRejCode_next;
      txTrain_reg <= txTrain_next;
    end
  end

  // transmit scrambler and output buffer
  lmac_scrambler txScr (.clk(clk), .srst(srst), .load(txScrLoad), .step(txScrStep),
    .seed(txSeed), .bitOut(txScrBit));
  lmac_fifo2 #(.W(SYM_W)) txBuf (.clk(clk), .srst(srst), .inP(symIn), .outP(symOut));
  assign symOut.ready = txSymReady;
  assign txSymValid = symOut.valid;
  assign txSymData = symOut.data;
  assign txSymLast = symOut.last;
  assign txReqReady = txReady_reg;
  assign txDone = txDone_reg;
  assign txReject = txRej_reg;
  assign txRejectCode = txRejCode_reg;
  assign txTrainSeq = txTrain_reg;

  // receive state
  lmac_state_t rxState_reg, rxState_next;
  logic [BLK_W-1:0] rxBlk_reg, rxBlk_next; // block being gathered
  logic [LEN_W-1:0] rxIdx_reg, rxIdx_next; // bit position
  logic [LEN_W-1:0] rxLen_reg, rxLen_next;
  logic [3:0] rxChan_reg, rxChan_next;
  logic [CRC_W-1:0] rxCrc_reg, rxCrc_next;
  logic rxOdd_reg, rxOdd_next;
  logic rxCrcBad_reg, rxCrcBad_next;
  logic rxLenBad_reg, rxLenBad_next;
  logic rxFlag_reg, rxFlag_next;
  logic [7:0] rxRssi_reg, rxRssi_next;
  logic indValid_reg, indValid_next;
  logic [BLK_W-1:0] indBlk_reg, indBlk_next;
  logic indPass_reg, indPass_next;
  logic indRptV_reg, indRptV_next;
  logic [RPT_W-1:0] indRpt_reg, indRpt_next;
  logic rxScrLoad, rxScrStep, rxScrBit, rxBit;

  // receive next state
  always_comb begin
    rxState_next = rxState_reg;
    rxBlk_next = rxBlk_reg;
    rxIdx_next = rxIdx_reg;
    rxLen_next = rxLen_reg;
    rxChan_next = rxChan_reg;
    rxCrc_next = rxCrc_reg;
    rxOdd_next = rxOdd_reg;
    rxCrcBad_next = rxCrcBad_reg;
    rxLenBad_next = rxLenBad_reg;
    rxFlag_next = rxFlag_reg;
    rxRssi_next = rxRssi_reg;
    indValid_next = 1'b0;
    indBlk_next = indBlk_reg;
    indPass_next = indPass_reg;
    indRptV_next = indRptV_reg;
    indRpt_next = indRpt_reg;
    rxScrLoad = 1'b0;
    rxScrStep = 1'b0;
    // de-interleave, take the systematic bit and descramble it
    rxBit = (rxOdd_reg ? rxSymData[1] : rxSymData[0]) ^ rxScrBit;
    if (rxStart) begin
      rxBlk_next = '0;
      rxIdx_next = '0;
      rxLen_next = rxLength;
      rxChan_next = rxChan;
      rxCrc_next = CRC_INIT;
      rxOdd_next = 1'b0;
      rxCrcBad_next = 1'b0;
      rxLenBad_next = !lenOk(rxChan, rxLength);
      rxFlag_next = (rxTrainSeq == TRAIN_STOLEN);
      rxRssi_next = rxRssi;
      rxScrLoad = 1'b1;
      rxState_next = ST_DATA;
    end else if (rxSymValid && rxState_reg != ST_IDLE) begin
      rxScrStep = 1'b1;
      rxOdd_next = ~rxOdd_reg;
      rxIdx_next = rxIdx_reg + 9'h001;
      if (rxState_reg == ST_DATA) begin
        rxBlk_next[BLK_W-1-rxIdx_reg] = rxBit;
        rxCrc_next = {rxCrc_reg[CRC_W-2:0], 1'b0}
          ^ ((rxBit ^ rxCrc_reg[CRC_W-1]) ? CRC_POLY : 16'h0000);
        if (rxIdx_reg == rxLen_reg - 9'h001) begin
          rxIdx_next = '0;
          rxState_next = ST_CRC;
        end
      end else begin
        rxCrc_next = {rxCrc_reg[CRC_W-2:0], 1'b0};
        if (rxBit != ~rxCrc_reg[CRC_W-1]) begin
          rxCrcBad_next = 1'b1;
        end
        if (rxIdx_reg == CRC_BITS - 9'h001) begin
          indValid_next = 1'b1;
          indPass_next = !(rxCrcBad_next || rxLenBad_reg);
          // a failed block is discarded, only its flags go up
          indBlk_next = indPass_next ? rxBlk_reg : '0;
          indRptV_next = !indPass_next;
          indRpt_next = rxLenBad_reg ? RPT_LEN : (rxCrcBad_next ? RPT_CRC : RPT_NONE);
          rxState_next = ST_IDLE;
        end
      end
    end
  end

  // receive registers
  always_ff @(posedge clk) begin
    if (srst) begin
      rxState_reg <= ST_IDLE;
      rxBlk_reg <= '0;
      rxIdx_reg <= '0;
      rxLen_reg <= '0;
      rxChan_reg <= 4'h0;
      rxCrc_reg <= CRC_INIT;
      rxOdd_reg <= 1'b0;
      rxCrcBad_reg <= 1'b0;
      rxLenBad_reg <= 1'b0;
      rxFlag_reg <= 1'b0;
      rxRssi_reg <= 8'h00;
      indValid_reg <= 1'b0;
      indBlk_reg <= '0;
      indPass_reg <= 1'b0;
      indRptV_reg <= 1'b0;
      indRpt_reg <= RPT_NONE;
    end else begin
      rxState_reg <= rxState_next;
      rxBlk_reg <= rxBlk_next;
      rxIdx_reg <= rxIdx_next;
      rxLen_reg <= rxLen_next;
      rxChan_reg <= rxChan_next;
      rxCrc_reg <= rxCrc_next;
      rxOdd_reg <= rxOdd_next;
      rxCrcBad_reg <= rxCrcBad_next;
      rxLenBad_reg <= rxLenBad_next;
      rxFlag_reg <= rxFlag_next;
      rxRssi_reg <= rxRssi_next;
      indValid_reg <= indValid_next;
      indBlk_reg <= indBlk_next;
      indPass_reg <= indPass_next;
      indRptV_reg <= indRptV_next;
      indRpt_reg <= indRpt_next;
    end
  end

  // receive descrambler
  lmac_scrambler rxScr (.clk(clk), .srst(srst), .load(rxScrLoad), .step(rxScrStep),
    .seed(rxCode), .bitOut(rxScrBit));

  // receive indication outputs
  assign rxIndValid = indValid_reg;
  assign rxIndBlock = indBlk_reg;
  assign rxIndLength = rxLen_reg;
  assign rxIndChan = rxChan_reg;
  assign rxIndCrcPass = indPass_reg;
  assign rxIndSlotFlag = rxFlag_reg;
  assign rxIndRssi = rxRssi_reg;
  assign rxIndRptValid = indRptV_reg;
  assign rxIndRpt = indRpt_reg;
endmodule
`default_nettype wire

//--- hw/lmac_pkg.sv
// Purpose: shared constants and types for the lower mac block service
// Assumes: one 20 MHz clock, synchronous active-high reset
// Notes: block vectors are left justified, first bit in the msb
package lmac_pkg;
  // block and field widths
  localparam int BLK_W = 268;
  localparam int LEN_W = 9;
  localparam int CODE_W = 30;
  localparam int CRC_W = 16;
  localparam int RPT_W = 2;
  // channel sdu sizes in bits
  localparam logic [8:0] SIZE_SCH_HU = 9'h05C;
  localparam logic [8:0] SIZE_SCH_F = 9'h10C;
  localparam logic [8:0] SIZE_STCH = 9'h07C;
  localparam logic [8:0] SIZE_SCH_HD = 9'h07C;
  localparam logic [8:0] SIZE_MAX = 9'h10C;
  // crc residue handling
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [8:0] CRC_BITS = 9'h010;
  // scrambler feedback taps and seed prefix
  localparam logic [31:0] SCR_TAPS = 32'h04C11DB7;
  localparam logic [1:0] SCR_PREFIX = 2'h3;
  // training sequences selected by the slot flag
  localparam logic [1:0] TRAIN_NORMAL = 2'h1;
  localparam logic [1:0] TRAIN_STOLEN = 2'h2;
  // exception report codes
  localparam logic [1:0] RPT_NONE = 2'h0;
  localparam logic [1:0] RPT_LEN = 2'h1;
  localparam logic [1:0] RPT_MAP = 2'h2;
  localparam logic [1:0] RPT_CRC = 2'h3;
  // buffer shape
  localparam int SYM_W = 2;
  // logical channels
  typedef enum logic [3:0] {
    CH_AACH = 4'h0, CH_SCH_HU = 4'h1, CH_SCH_HD = 4'h2, CH_SCH_F = 4'h3,
    CH_STCH = 4'h4, CH_TCH = 4'h5, CH_BSCH = 4'h6
  } lmac_chan_t;
  // pdu types
  typedef enum logic [3:0] {
    PDU_ACC_ASSIGN = 4'h0, PDU_ACC_DEFINE = 4'h1, PDU_ACCESS = 4'h2,
    PDU_END_HU = 4'h3, PDU_DATA = 4'h4, PDU_RESOURCE = 4'h5,
    PDU_FRAG = 4'h6, PDU_END = 4'h7, PDU_TRAFFIC = 4'h8,
    PDU_USIGNAL = 4'h9, PDU_SYNC = 4'hA, PDU_SYSINFO = 4'hB
  } lmac_pdu_t;
endpackage

//--- hw/lmac_strm_if.sv
// Purpose: valid/ready symbol stream between core and buffer
// Assumes: single clock domain
// Notes: a word moves when valid and ready are both high
`timescale 1ns/1ps
`default_nettype none
interface lmac_strm_if #(parameter int W = 2);
  logic valid; // word offered
  logic ready; // word accepted
  logic last; // final word of a burst
  logic [W-1:0] data; // symbol
  modport src (output valid, output last, output data, input ready);
  modport dst (input valid, input last, input data, output ready);
endinterface
`default_nettype wire

//--- hw/lmac_fifo2.sv
// Purpose: two-entry buffer so a receiver stall loses no symbol
// Assumes: source honours ready
// Notes: outputs come from registers
`timescale 1ns/1ps
`default_nettype none
module lmac_fifo2 #(parameter int W = 2) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // streams
  lmac_strm_if.dst inP,
  lmac_strm_if.src outP
);
  logic [W:0] mem_reg [2]; // data plus last per entry
  logic [W:0] mem_next [2];
  logic wrPtr_reg, wrPtr_next; // write slot
  logic rdPtr_reg, rdPtr_next; // read slot
  logic [1:0] count_reg, count_next; // entries held
  logic push, pop;

  // next state of the buffer
  always_comb begin
    push = inP.valid && (count_reg != 2'h2);
    pop = (count_reg != 2'h0) && outP.ready;
    mem_next = mem_reg;
    wrPtr_next = wrPtr_reg;
    rdPtr_next = rdPtr_reg;
    if (push) begin
      mem_next[wrPtr_reg] = {inP.last, inP.data};
      wrPtr_next = ~wrPtr_reg;
    end
    if (pop) begin
      rdPtr_next = ~rdPtr_reg;
    end
    count_next = count_reg + {1'b0, push} - {1'b0, pop};
  end

  // register the buffer
  always_ff @(posedge clk) begin
    if (srst) begin
      mem_reg[0] <= '0;
      mem_reg[1] <= '0;
      wrPtr_reg <= 1'b0;
      rdPtr_reg <= 1'b0;
      count_reg <= 2'h0;
    end else begin
      mem_reg <= mem_next;
      wrPtr_reg <= wrPtr_next;
      rdPtr_reg <= rdPtr_next;
      count_reg <= count_next;
    end
  end

  // honest full and empty
  assign inP.ready = (count_reg != 2'h2);
  assign outP.valid = (count_reg != 2'h0);
  assign outP.data = mem_reg[rdPtr_reg][W-1:0];
  assign outP.last = mem_reg[rdPtr_reg][W];
endmodule
`default_nettype wire

//--- hw/lmac_scrambler.sv
// Purpose: scrambling sequence generator seeded by the extended colour code
// Assumes: load and step never in the same cycle
// Notes: bitOut is the bit for the current position
`timescale 1ns/1ps
`default_nettype none
module lmac_scrambler
  import lmac_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // control
  input wire logic load,
  input wire logic step,
  input wire logic [CODE_W-1:0] seed,
  // sequence
  output logic bitOut
);
  logic [31:0] lfsr_reg, lfsr_next; // generator state

  // seed or advance the generator
  always_comb begin
    lfsr_next = lfsr_reg;
    if (load) begin
      lfsr_next = {SCR_PREFIX, seed};
    end else if (step) begin
      lfsr_next = {lfsr_reg[30:0], ^(lfsr_reg & SCR_TAPS)};
    end
  end

  // register the generator
  always_ff @(posedge clk) begin
    if (srst) begin
      lfsr_reg <= 32'hFFFFFFFF;
    end else begin
      lfsr_reg <= lfsr_next;
    end
  end

  assign bitOut = lfsr_reg[31];
endmodule
`default_nettype wire

//--- tb/lmac_checker.sv
// Purpose: port assertions for lmac_core
// Assumes: one clock, srst synchronous active high
// Notes: size and mapping tables kept apart from the design
`timescale 1ns/1ps
`default_nettype none
module lmac_checker
  import lmac_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // transmit request and result
  input wire logic txReqValid,
  input wire logic txReqReady,
  input wire logic [LEN_W-1:0] txLength,
  input wire logic [3:0] txChan,
  input wire logic [3:0] txPdu,
  input wire logic txSlotFlag,
  input wire logic txDone,
  input wire logic txReject,
  input wire logic [RPT_W-1:0] txRejectCode,
  input wire logic [1:0] txTrainSeq,
  // coded symbols
  input wire logic txSymValid,
  input wire logic txSymReady,
  input wire logic [SYM_W-1:0] txSymData,
  // receive indication
  input wire logic rxIndValid,
  input wire logic [BLK_W-1:0] rxIndBlock,
  input wire logic rxIndCrcPass,
  input wire logic rxIndRptValid,
  input wire logic [RPT_W-1:0] rxIndRpt
);
  // allowed channel mask per pdu
  function automatic logic [6:0] chMask(input logic [3:0] p);
    case (p)
      4'h0: return 7'h01;
      4'h1, 4'h5, 4'h7: return 7'h1C;
      4'h2, 4'h3: return 7'h02;
      4'h4: return 7'h18;
      4'h6: return 7'h0C;
      4'h8: return 7'h20;
      4'h9: return 7'h10;
      4'hA: return 7'h40;
      4'hB: return 7'h14;
      default: return 7'h00;
    endcase
  endfunction
  logic take; // request taken this edge
  logic lenOk; // length fits the channel
  logic mapOk; // pdu allowed on the channel
  logic [6:0] msk; // allowed channels
  assign take = txReqValid && txReqReady;
  assign msk = chMask(txPdu);
  assign mapOk = txChan < 4'h7 && msk[txChan[2:0]];
  // channel sizes, else 1..268
  always_comb begin
    case (txChan)
      4'h1: lenOk = txLength == 9'h05C;
      4'h2, 4'h4: lenOk = txLength == 9'h07C;
      4'h3: lenOk = txLength == 9'h10C;
      default: lenOk = txLength != 9'h000 && txLength <= 9'h10C;
    endcase
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  chk_len_reject: assert property (take && !lenOk |=> txReject && txRejectCode == 2'h1 && txReqReady)
    else $error("wrong length not refused");
  chk_map_reject: assert property (take && lenOk && !mapOk |=> txReject && txRejectCode == 2'h2)
    else $error("bad mapping not refused");
  chk_good_accept: assert property (take && lenOk && mapOk |=> !txReject && !txReqReady)
    else $error("legal request not accepted");
  chk_train_pick: assert property (take && lenOk && mapOk |=> txTrainSeq == ($past(txSlotFlag) ? 2'h2 : 2'h1))
    else $error("training sequence wrong");
  chk_stall_hold: assert property (txSymValid && !txSymReady |=> txSymValid && $stable(txSymData))
    else $error("symbol lost under stall");
  chk_done_ready: assert property (txDone |=> txReqReady && !txDone)
    else $error("not idle after done");
  chk_ind_pulse: assert property (rxIndValid |=> !rxIndValid)
    else $error("indication longer than a cycle");
  chk_fail_zero: assert property (rxIndValid && !rxIndCrcPass |-> rxIndBlock == '0 && rxIndRptValid && rxIndRpt != 2'h0)
    else $error("failed block not discarded");
  chk_reset_idle: assert property (@(posedge clk) disable iff (1'b0) srst |=> txReqReady && !txSymValid)
    else $error("not idle after reset");
endmodule
`default_nettype wire

//--- tb/lmac_sink.sv
// Purpose: behavioural receiver of the coded symbol stream
// Assumes: stream moves on valid and ready
// Notes: stalls one cycle in four; keeps the last frame for replay
`timescale 1ns/1ps
`default_nettype none
module lmac_sink (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // symbol stream from the core
  input wire logic symValid,
  input wire logic [1:0] symData,
  input wire logic symLast,
  output logic symReady
);
  logic [1:0] mem [0:283]; // captured frame
  int cnt; // symbols in the frame
  logic seenLast; // frame closed
  logic [1:0] phase; // stall pattern
  // capture, restart after last
  always_ff @(posedge clk) begin
    if (srst) begin
      phase <= 2'h0;
      cnt <= 0;
      seenLast <= 1'b0;
    end else begin
      phase <= phase + 2'h1;
      if (symValid && symReady) begin
        mem[seenLast ? 0 : cnt] <= symData;
        cnt <= seenLast ? 1 : cnt + 1;
        seenLast <= symLast;
      end
    end
  end
  // stall so the buffer has to hold words
  assign symReady = !srst && phase != 2'h3;
endmodule
`default_nettype wire

//--- tb/tb_top.sv
// Purpose: self-checking bench for lmac_core
// Assumes: 50 ns clock, inputs driven on the falling edge
// Notes: each frame sent in the row loop loops back through the sink into rx
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import lmac_pkg::*;
;
  localparam int B = BLK_W;
  typedef struct packed {logic [3:0] ch; logic [3:0] pdu; logic [8:0] len; logic [1:0] code;} lmac_row_t;
  // channel, pdu, length, refusal code; blocks sized, one pdu each
  lmac_row_t rows [18] = '{
    '{4'h0, 4'h0, 9'h00E, 2'h0}, '{4'h2, 4'h1, 9'h07C, 2'h0}, '{4'h1, 4'h2, 9'h05C, 2'h0},
    '{4'h1, 4'h3, 9'h05C, 2'h0}, '{4'h3, 4'h4, 9'h10C, 2'h0}, '{4'h4, 4'h5, 9'h07C, 2'h0},
    '{4'h2, 4'h6, 9'h07C, 2'h0}, '{4'h3, 4'h7, 9'h10C, 2'h0}, '{4'h5, 4'h8, 9'h10C, 2'h0},
    '{4'h4, 4'h9, 9'h07C, 2'h0}, '{4'h6, 4'hA, 9'h03C, 2'h0}, '{4'h4, 4'hB, 9'h07C, 2'h0},
    '{4'h1, 4'h2, 9'h05B, 2'h1}, '{4'h3, 4'h4, 9'h10B, 2'h1}, '{4'h4, 4'h9, 9'h07D, 2'h1},
    '{4'h3, 4'h8, 9'h10C, 2'h2}, '{4'h0, 4'hA, 9'h000, 2'h1}, '{4'h1, 4'h4, 9'h05C, 2'h2}};
  logic clk, srst, txReqValid, txReqReady, txSlotFlag, txDone, txReject, txSymValid, txSymReady;
  logic txSymLast, rxStart, rxSymValid, rxIndValid, rxIndCrcPass, rxIndSlotFlag, rxIndRptValid;
  logic [BLK_W-1:0] txBlock, rxIndBlock;
  logic [LEN_W-1:0] txLength, rxLength, rxIndLength;
  logic [3:0] txChan, txPdu, rxChan, rxIndChan;
  logic [9:0] txCountry;
  logic [13:0] txNetwork;
  logic [5:0] txColour;
  logic [RPT_W-1:0] txRejectCode, rxIndRpt;
  logic [1:0] txTrainSeq, rxTrainSeq, txSymData, rxSymData;
  logic [CODE_W-1:0] rxCode;
  logic [7:0] rxRssi, rxIndRssi;
  int error_cnt = 0;
  int samples_checked = 0;
  int cyc = 0;
  // device under test
  lmac_core lmac_core_inst (.*);
  // far side symbol receiver
  lmac_sink lmac_sink_inst (.clk(clk), .srst(srst), .symValid(txSymValid),
    .symData(txSymData), .symLast(txSymLast), .symReady(txSymReady));
  // clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      wrap_up();
    end
  end
  // compare and count
  task automatic check(input logic [BLK_W-1:0] seen, input logic [BLK_W-1:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // closing report
  task automatic wrap_up();
    $display("errors=%0d checks=%0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // offer row i for one edge
  task automatic offer(input int i);
    txChan = rows[i].ch;
    txPdu = rows[i].pdu;
    txLength = rows[i].len;
    txBlock = {67{4'(i + 5)}};
    txSlotFlag = i[0];
    txReqValid = 1'b1;
    @(negedge clk);
    txReqValid = 1'b0;
  endtask
  // follow an accepted request to its end
  task automatic finishTx(input logic [8:0] n, input logic sf);
    int k;
    check(B'(txReqReady), B'(1'b0));
    for (k = 0; k < 2000 && txDone !== 1'b1; k++) @(negedge clk);
    check(B'(txDone), B'(1'b1));
    @(negedge clk);
    check(B'(txReqReady), B'(1'b1));
    for (k = 0; k < 20 && lmac_sink_inst.seenLast !== 1'b1; k++) @(negedge clk);
    check(B'(lmac_sink_inst.cnt), B'(n) + B'(16));
    check(B'(txTrainSeq), B'(sf ? TRAIN_STOLEN : TRAIN_NORMAL));
  endtask
  // replay the captured frame into the receive path
  task automatic rxRun(input logic [8:0] n, input logic [3:0] ch, input logic [29:0] code,
      input logic sf, input int nsym);
    int k;
    rxStart = 1'b1;
    rxLength = n;
    rxChan = ch;
    rxCode = code;
    rxTrainSeq = sf ? TRAIN_STOLEN : TRAIN_NORMAL;
    rxRssi = n[7:0];
    @(negedge clk);
    rxStart = 1'b0;
    for (k = 0; k < nsym; k++) begin
      rxSymValid = 1'b1;
      rxSymData = lmac_sink_inst.mem[k];
      @(negedge clk);
    end
    rxSymValid = 1'b0;
    rxSymData = ~rxSymData;
    for (k = 0; k < 4 && rxIndValid !== 1'b1; k++) @(negedge clk);
    check(B'(rxIndValid), B'(1'b1));
    check(B'({rxIndLength, rxIndChan, rxIndRssi}), B'({n, ch, n[7:0]}));
  endtask
  // main sequence
  initial begin
    logic [BLK_W-1:0] msk;
    srst = 1'b1;
    {txReqValid, txSlotFlag, rxStart, rxSymValid} = 4'h0;
    {txBlock, txLength, txChan, txPdu} = '0;
    {rxLength, rxChan, rxCode, rxTrainSeq, rxRssi, rxSymData} = '0;
    txCountry = 10'h2A5;
    txNetwork = 14'h1B3C;
    txColour = 6'h2D;
    repeat (20) @(negedge clk);
    srst = 1'b0;
    for (int i = 0; i < 18; i++) begin
      offer(i);
      check(B'(txReject), B'(rows[i].code != 2'h0));
      if (rows[i].code != 2'h0) begin
        check(B'({txRejectCode, txReqReady}), B'({rows[i].code, 1'b1}));
        @(negedge clk);
      end else begin
        finishTx(rows[i].len, i[0]);
        rxRun(rows[i].len, rows[i].ch, {txCountry, txNetwork, txColour}, i[0], rows[i].len + 16);
        msk = ~({BLK_W{1'b1}} >> rows[i].len);
        check(rxIndBlock & msk, txBlock & msk);
        check(B'({rxIndCrcPass, rxIndRptValid, rxIndSlotFlag}), B'({2'b10, i[0]}));
      end
    end
    // wrong code: block dropped
    rxRun(9'h07C, CH_STCH, {txCountry, txNetwork, txColour} ^ 30'h1, 1'b1, 140);
    check(rxIndBlock, '0);
    check(B'({rxIndCrcPass, rxIndRptValid, rxIndRpt}), B'({2'b01, RPT_CRC}));
    // rx length wrong for channel
    rxRun(9'h05C, CH_STCH, {txCountry, txNetwork, txColour}, 1'b1, 108);
    check(B'({rxIndRptValid, rxIndRpt}), B'({1'b1, RPT_LEN}));
    // mid-frame reset, request at first edge after
    offer(4);
    repeat (20) @(negedge clk);
    srst = 1'b1;
    @(negedge clk);
    srst = 1'b0;
    check(B'({txReqReady, txSymValid, rxIndValid}), B'(3'b100));
    offer(4);
    finishTx(9'h10C, 1'b0);
    wrap_up();
  end
endmodule
bind lmac_core lmac_checker lmac_checker_inst (.*);
`default_nettype wire
